// *** sadc_pkg.sv ***
package sadc_pkg;
   // ************************************************************
   // register map
   // ************************************************************
   localparam logic [7:0] SADC_CTRL_ADDR = 8'h00;
   localparam logic [7:0] SADC_CFG_ADDR = 8'h04;
   localparam logic [7:0] SADC_STAT_ADDR = 8'h08;
   localparam logic [7:0] SADC_RESH_ADDR = 8'h0c;
   localparam logic [7:0] SADC_RESL_ADDR = 8'h10;
   // control word fields
   localparam int SADC_ENA_BIT = 0;
   localparam int SADC_GO_BIT = 1;
   localparam int SADC_CHS_LSB = 2;
   localparam int SADC_CHS_W = 6;
   // config word fields
   localparam int SADC_PREF_LSB = 0;
   localparam int SADC_NREF_BIT = 2;
   localparam int SADC_JUST_BIT = 3;
   localparam int SADC_CKS_LSB = 4;
   // status word fields
   localparam int SADC_DONE_BIT = 0;
   // ************************************************************
   // timing
   // ************************************************************
   localparam int SADC_RES_W = 10;
   localparam logic [3:0] SADC_PERIODS = 4'hc;   // bit periods per conversion
   localparam logic [3:0] SADC_FIRST_BIT = 4'h1; // period resolving the msb
   localparam logic [5:0] SADC_DIV_ONE = 6'h01;
   localparam logic [2:0] SADC_CKS_RST = 3'h0;
   typedef enum logic [1:0] {SADC_IDLE, SADC_CONV} sadc_state_t;
endpackage : sadc_pkg

// *** sadc_clkdiv.sv ***
`timescale 1ns/10ps
// ************************************************************
// bit period tick generator
// ************************************************************
module sadc_clkdiv (
   input wire logic clk,
   input wire logic resetn,
   input wire logic run,
   input wire logic [2:0] sel,
   input wire logic rcTick,
   output logic tick
);
   import sadc_pkg::*;
   typedef struct packed {
      logic [5:0] cnt;
   } sadc_div_t;
   sadc_div_t s_q, s_d;
   logic [5:0] half;
   // divider terminal count: 000 /2, 100 /4, 001 /8, 101 /16, 010 /32, 110 /64
   always_comb begin
      half = 6'h00;
      unique case ({sel[1:0], sel[2]})
         3'b000: half = 6'h01;
         3'b001: half = 6'h03;
         3'b010: half = 6'h07;
         3'b011: half = 6'h0f;
         3'b100: half = 6'h1f;
         default: half = 6'h3f;
      endcase
   end
   // counter follows system clock unless rc selected
   always_comb begin
      s_d = s_q;
      tick = 1'b0;
      if (sel[1:0] == 2'b11) begin
         tick = run && rcTick;
         s_d.cnt = 6'h00;
      end else if (!run) begin
         s_d.cnt = 6'h00;
      end else if (s_q.cnt == half) begin
         tick = 1'b1;
         s_d.cnt = 6'h00;
      end else begin
         s_d.cnt = s_q.cnt + SADC_DIV_ONE;
      end
   end
   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         s_q <= '0;
      end else begin
         s_q <= s_d;
      end
   end
endmodule : sadc_clkdiv

// *** sadc_ctrl.sv ***
// The address map and the APB slave port were decided locally.
`timescale 1ns/10ps
module sadc_ctrl (
   input wire logic clk,
   input wire logic resetn,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [7:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   input wire logic rcTick,
   input wire logic cmpHigh,
   output logic [5:0] channelSelect,
   output logic [1:0] posRefSelect,
   output logic negRefSelect,
   output logic [9:0] dacTrial,
   output logic sampleHold,
   output logic convIrq
);
   import sadc_pkg::*;
   typedef struct packed {
      sadc_state_t st;
      logic ena;
      logic go;
      logic [5:0] chs;
      logic [1:0] pref;
      logic nref;
      logic just;
      logic [2:0] cks;
      logic done;
      logic [3:0] per;
      logic [9:0] sar;
      logic [3:0] lastIdx;
      logic [7:0] resH;
      logic [7:0] resL;
      logic [31:0] rdata;
   } sadc_state_q_t;
   sadc_state_q_t s_q, s_d;
   logic tick;
   logic wr, rd, hit;
   logic [9:0] fill, val;
   logic [3:0] bitIdx;
   // ************************************************************
   // bit period timing
   // ************************************************************
   sadc_clkdiv u_div (
      .clk(clk),
      .resetn(resetn),
      .run(s_q.st == SADC_CONV),
      .sel(s_q.cks),
      .rcTick(rcTick),
      .tick(tick)
   );
   assign wr = psel && penable && pwrite;
   assign rd = psel && penable && !pwrite;
   assign hit = (paddr == SADC_CTRL_ADDR) || (paddr == SADC_CFG_ADDR)
      || (paddr == SADC_STAT_ADDR) || (paddr == SADC_RESH_ADDR)
      || (paddr == SADC_RESL_ADDR);
   // partial result: unresolved bits copy last resolved bit
   always_comb begin
      fill = s_q.sar;
      for (int i = 0; i < SADC_RES_W; i++) begin
         if (s_q.lastIdx != 4'hf && i < s_q.lastIdx) begin
            fill[i] = s_q.sar[s_q.lastIdx];
         end
      end
   end
   // ************************************************************
   // main sequencing
   // ************************************************************
   always_comb begin
      s_d = s_q;
      val = '0;
      bitIdx = 4'(SADC_PERIODS - 4'h2) - s_q.per;
      // register writes
      if (wr) begin
         unique case (paddr)
            SADC_CTRL_ADDR: begin
               s_d.ena = pwdata[SADC_ENA_BIT];
               s_d.go = pwdata[SADC_GO_BIT] && s_q.ena;
               s_d.chs = pwdata[SADC_CHS_LSB +: SADC_CHS_W];
            end
            SADC_CFG_ADDR: begin
               s_d.pref = pwdata[SADC_PREF_LSB +: 2];
               s_d.nref = pwdata[SADC_NREF_BIT];
               s_d.just = pwdata[SADC_JUST_BIT];
               s_d.cks = pwdata[SADC_CKS_LSB +: 3];
            end
            SADC_STAT_ADDR: begin
               if (pwdata[SADC_DONE_BIT]) s_d.done = 1'b0;
            end
            default: begin
            end
         endcase
      end
      unique case (s_q.st)
         SADC_IDLE: begin
            if (s_q.go && s_q.ena) begin
               s_d.st = SADC_CONV;
               s_d.per = '0;
               s_d.sar = '0;
               s_d.lastIdx = 4'hf;
            end
         end
         SADC_CONV: begin
            if (!s_d.go || !s_q.ena) begin
               val = fill;
               s_d.st = SADC_IDLE;
               s_d.go = 1'b0;
               s_d.done = 1'b1;
            end else if (tick) begin
               // period 0 sample, 1..10 bits msb first, 11 finish
               if (s_q.per >= SADC_FIRST_BIT && s_q.per < SADC_PERIODS - SADC_FIRST_BIT) begin
                  s_d.sar[bitIdx] = cmpHigh;
                  s_d.lastIdx = bitIdx;
               end
               if (s_q.per == SADC_PERIODS - SADC_FIRST_BIT) begin
                  val = s_q.sar;
                  s_d.st = SADC_IDLE;
                  s_d.go = 1'b0;
                  s_d.done = 1'b1;
               end
               s_d.per = s_q.per + 4'h1;
            end
         end
      endcase
      // result update in chosen alignment
      if (s_q.st == SADC_CONV && s_d.st == SADC_IDLE) begin
         if (s_q.just) begin
            s_d.resH = {6'h00, val[9:8]};
            s_d.resL = val[7:0];
         end else begin
            s_d.resH = val[9:2];
            s_d.resL = {val[1:0], 6'h00};
         end
      end
      // read data
      s_d.rdata = '0;
      if (psel && !penable && !pwrite) begin
         unique case (paddr)
            SADC_CTRL_ADDR: s_d.rdata = {24'h0, s_q.chs, s_q.go, s_q.ena};
            SADC_CFG_ADDR: s_d.rdata = {25'h0, s_q.cks, s_q.just, s_q.nref, s_q.pref};
            SADC_STAT_ADDR: s_d.rdata = {31'h0, s_q.done};
            SADC_RESH_ADDR: s_d.rdata = {24'h0, s_q.resH};
            SADC_RESL_ADDR: s_d.rdata = {24'h0, s_q.resL};
            default: s_d.rdata = '0;
         endcase
      end else if (rd) begin
         s_d.rdata = s_q.rdata;
      end
   end
   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         s_q <= '{st: SADC_IDLE, lastIdx: 4'hf, cks: SADC_CKS_RST, default: '0};
      end else begin
         s_q <= s_d;
      end
   end
   // ************************************************************
   // outputs
   // ************************************************************
   assign prdata = s_q.rdata;
   assign pready = 1'b1;
   assign pslverr = psel && penable && !hit;
   assign channelSelect = s_q.chs;
   assign posRefSelect = s_q.pref;
   assign negRefSelect = s_q.nref;
   assign sampleHold = (s_q.st == SADC_CONV) && (s_q.per == 4'h0);
   assign convIrq = s_q.done;
   // trial word: resolved bits plus the bit under test
   always_comb begin
      dacTrial = s_q.sar;
      if (s_q.st == SADC_CONV && s_q.per >= SADC_FIRST_BIT
          && s_q.per < SADC_PERIODS - SADC_FIRST_BIT) begin
         dacTrial[bitIdx] = 1'b1;
      end
   end
   // ************************************************************
   // checks
   // ************************************************************
   property p_done_clears_go;
      @(posedge clk) disable iff (!resetn)
      (s_q.st == SADC_CONV && s_d.st == SADC_IDLE) |=> !s_q.go && s_q.done;
   endproperty
   a_done_clears_go: assert property (p_done_clears_go) else $error("go left set at done");
   property p_irq_follows;
      @(posedge clk) disable iff (!resetn)
      (s_q.st == SADC_CONV && s_d.st == SADC_IDLE) |=> convIrq;
   endproperty
   a_irq_follows: assert property (p_irq_follows) else $error("irq missing");
   property p_chs_write;
      @(posedge clk) disable iff (!resetn)
      (wr && paddr == SADC_CTRL_ADDR) |=> channelSelect == $past(pwdata[7:2]);
   endproperty
   a_chs_write: assert property (p_chs_write) else $error("channel not stored");
   property p_pref_write;
      @(posedge clk) disable iff (!resetn)
      (wr && paddr == SADC_CFG_ADDR) |=> posRefSelect == $past(pwdata[1:0])
         && negRefSelect == $past(pwdata[2]);
   endproperty
   a_pref_write: assert property (p_pref_write) else $error("ref not stored");
   property p_go_needs_ena;
      @(posedge clk) disable iff (!resetn)
      (wr && paddr == SADC_CTRL_ADDR && !s_q.ena) |=> !s_q.go;
   endproperty
   a_go_needs_ena: assert property (p_go_needs_ena) else $error("go without enable");
   property p_right_just;
      @(posedge clk) disable iff (!resetn)
      (s_q.st == SADC_CONV && s_d.st == SADC_IDLE && s_q.just) |=> s_q.resH[7:2] == 6'h00;
   endproperty
   a_right_just: assert property (p_right_just) else $error("bad right justify");
   property p_fast_tick;
      @(posedge clk) disable iff (!resetn)
      (tick && s_q.cks == 3'b000 && s_q.st == SADC_CONV) |=> !tick ##1 1'b1;
   endproperty
   a_fast_tick: assert property (p_fast_tick) else $error("divide by two wrong");
   property p_rc_tick;
      @(posedge clk) disable iff (!resetn)
      (s_q.cks[1:0] == 2'b11 && s_q.st == SADC_CONV && !rcTick) |-> !tick;
   endproperty
   a_rc_tick: assert property (p_rc_tick) else $error("rc tick leak");
   property p_period_bound;
      @(posedge clk) disable iff (!resetn)
      s_q.st == SADC_CONV |-> s_q.per < SADC_PERIODS;
   endproperty
   a_period_bound: assert property (p_period_bound) else $error("too many periods");
   // ************************************************************
   // sequencing checks
   // ************************************************************
   property p_sample_first;
      @(posedge clk) disable iff (!resetn)
      $rose(s_q.st == SADC_CONV) |-> sampleHold;
   endproperty
   a_sample_first: assert property (p_sample_first) else $error("no sample period");
   property p_trial_msb;
      @(posedge clk) disable iff (!resetn)
      (s_q.st == SADC_CONV && s_q.per == SADC_FIRST_BIT) |-> dacTrial == 10'h200;
   endproperty
   a_trial_msb: assert property (p_trial_msb) else $error("msb not tried first");
   property p_per_hold;
      @(posedge clk) disable iff (!resetn)
      (s_q.st == SADC_CONV && !tick) |=> s_q.per == $past(s_q.per);
   endproperty
   a_per_hold: assert property (p_per_hold) else $error("period moved without tick");
   property p_tick_advances;
      @(posedge clk) disable iff (!resetn)
      (s_q.st == SADC_CONV && s_d.st == SADC_CONV && tick)
         |=> s_q.per == $past(s_q.per) + 4'h1;
   endproperty
   a_tick_advances: assert property (p_tick_advances) else $error("period stuck");
   property p_finish_twelve;
      @(posedge clk) disable iff (!resetn)
      (s_q.st == SADC_CONV && tick && s_q.per == SADC_PERIODS - SADC_FIRST_BIT)
         |=> s_q.st == SADC_IDLE && convIrq;
   endproperty
   a_finish_twelve: assert property (p_finish_twelve) else $error("no end at twelve");
   // results: full word at completion, held while idle, left alignment
   property p_result_word;
      @(posedge clk) disable iff (!resetn)
      (s_q.st == SADC_CONV && tick && s_q.per == SADC_PERIODS - SADC_FIRST_BIT)
         |=> ($past(s_q.just) ? {s_q.resH[1:0], s_q.resL} : {s_q.resH, s_q.resL[7:6]})
            == $past(s_q.sar);
   endproperty
   a_result_word: assert property (p_result_word) else $error("wrong result word");
   property p_res_hold;
      @(posedge clk) disable iff (!resetn)
      s_q.st == SADC_IDLE |=> $stable(s_q.resH) && $stable(s_q.resL);
   endproperty
   a_res_hold: assert property (p_res_hold) else $error("result moved while idle");
   property p_left_just;
      @(posedge clk) disable iff (!resetn)
      (s_q.st == SADC_CONV && s_d.st == SADC_IDLE && !s_q.just) |=> s_q.resL[5:0] == 6'h00;
   endproperty
   a_left_just: assert property (p_left_just) else $error("bad left justify");
   // done sticks until cleared, settings move only on writes
   property p_irq_held;
      @(posedge clk) disable iff (!resetn)
      (convIrq && !(wr && paddr == SADC_STAT_ADDR && pwdata[SADC_DONE_BIT])) |=> convIrq;
   endproperty
   a_irq_held: assert property (p_irq_held) else $error("flag dropped without clear");
   property p_irq_clear;
      @(posedge clk) disable iff (!resetn)
      (wr && paddr == SADC_STAT_ADDR && pwdata[SADC_DONE_BIT]
         && !(s_q.st == SADC_CONV && s_d.st == SADC_IDLE)) |=> !convIrq;
   endproperty
   a_irq_clear: assert property (p_irq_clear) else $error("flag not cleared");
   property p_cfg_hold;
      @(posedge clk) disable iff (!resetn)
      !wr |=> $stable(channelSelect) && $stable(posRefSelect) && $stable(negRefSelect);
   endproperty
   a_cfg_hold: assert property (p_cfg_hold) else $error("setting moved without write");
   c_start: cover property (@(posedge clk) $rose(s_q.st == SADC_CONV));
   c_done: cover property (@(posedge clk) $rose(s_q.done));
   c_abort: cover property (@(posedge clk) s_q.st == SADC_CONV && wr && !s_d.go);
   c_rc_tick: cover property (@(posedge clk) tick && s_q.cks[1:0] == 2'b11);
   c_left: cover property (@(posedge clk) $rose(s_q.done) && !s_q.just);
endmodule : sadc_ctrl

// *** sadc_analog_model.sv ***
`timescale 1ns/10ps
// ********
// analog sample-and-hold and comparator
// ********
module sadc_analog_model #(
   parameter int RC_DIV = 5
) (
   input wire logic clk,
   input wire logic resetn,
   input wire logic [9:0] vin,
   input wire logic [9:0] dacTrial,
   input wire logic sampleHold,
   output logic rcTick,
   output logic cmpHigh
);
   logic [9:0] held_q;
   int rcCnt_q;
   // capacitor follows vin while sampling; rc oscillator runs free
   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         held_q <= 10'h000;
         rcCnt_q <= 0;
         rcTick <= 1'b0;
      end else begin
         if (sampleHold) begin
            held_q <= vin;
         end
         rcCnt_q <= (rcCnt_q == RC_DIV - 1) ? 0 : rcCnt_q + 1;
         rcTick <= (rcCnt_q == RC_DIV - 1);
      end
   end
   // comparator against the trial code
   assign cmpHigh = (held_q >= dacTrial);
endmodule : sadc_analog_model

// *** tb.sv ***
`timescale 1ns/10ps
module tb;
   import sadc_pkg::*;
   localparam int RC_DIV = 5;
   localparam logic [5:0] GND_CH = 6'h3c; // ground channel code, value arbitrary
   logic clk, resetn, psel, penable, pwrite, pready, pslverr, err;
   logic rcTick, cmpHigh, negRefSelect, sampleHold, convIrq;
   logic [7:0] paddr;
   logic [31:0] pwdata, prdata, rd;
   logic [5:0] channelSelect;
   logic [1:0] posRefSelect;
   logic [9:0] dacTrial, vin;
   logic [31:0] seed = 32'h47;
   int n_fail = 0;
   int n_tests = 0;
   sadc_ctrl sadc_ctrl_i (.clk(clk), .resetn(resetn), .psel(psel), .penable(penable),
      .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
      .pslverr(pslverr), .rcTick(rcTick), .cmpHigh(cmpHigh),
      .channelSelect(channelSelect), .posRefSelect(posRefSelect),
      .negRefSelect(negRefSelect), .dacTrial(dacTrial), .sampleHold(sampleHold),
      .convIrq(convIrq));
   sadc_analog_model #(.RC_DIV(RC_DIV)) sadc_analog_model_i (.clk(clk), .resetn(resetn),
      .vin(vin), .dacTrial(dacTrial), .sampleHold(sampleHold), .rcTick(rcTick),
      .cmpHigh(cmpHigh));
   // ********
   // helpers
   // ********
   initial begin
      clk = 1'b0;
      forever #5 clk = ~clk;
   end
   function automatic logic [31:0] rnd();
      seed ^= seed << 13;
      seed ^= seed >> 17;
      seed ^= seed << 5;
      return seed;
   endfunction : rnd
   // bit period in clk cycles for a clock selection
   function automatic int div_of(logic [2:0] c);
      if (c[1:0] == 2'h3) return RC_DIV;
      return 1 << (1 + 2 * c[1:0] + c[2]);
   endfunction : div_of
   // expected result word for a justification
   function automatic logic [31:0] res_of(logic [9:0] r, logic just, logic hi);
      if (hi) return just ? {30'h0, r[9:8]} : {24'h0, r[9:2]};
      return just ? {24'h0, r[7:0]} : {24'h0, r[1:0], 6'h00};
   endfunction : res_of
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      n_tests++;
      if (got !== exp) begin
         n_fail++;
         $display("BAD t=%0t got %h exp %h", $time, got, exp);
      end
   endtask : chk
   // one apb transfer; answer taken at the edge that sees pready high
   task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
      int g;
      @(posedge clk);
      psel <= 1'b1;
      penable <= 1'b0;
      pwrite <= wr;
      paddr <= a;
      pwdata <= d;
      @(posedge clk);
      penable <= 1'b1;
      g = 0;
      do begin
         @(posedge clk);
         g++;
      end while (pready !== 1'b1 && g < 100);
      if (g >= 100) chk(32'h0, 32'h1);
      rd = prdata;
      err = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask : apb
   task automatic conv(input logic [2:0] cks, input logic just);
      logic [9:0] r;
      logic [5:0] ch;
      logic [2:0] p;
      logic sh;
      int n;
      r = 10'(rnd());
      ch = 6'(rnd());
      p = 3'(rnd());
      @(posedge clk);
      vin <= r;
      apb(1'b1, SADC_CTRL_ADDR, {24'h0, GND_CH, 2'h1});
      apb(1'b1, SADC_CFG_ADDR, {25'h0, cks, just, p});
      apb(1'b1, SADC_CTRL_ADDR, {24'h0, ch, 2'h1});
      repeat (4) @(posedge clk);
      @(negedge clk);
      chk(32'(channelSelect), 32'(ch));
      chk(32'(posRefSelect), 32'(p[1:0]));
      chk(32'(negRefSelect), 32'(p[2]));
      apb(1'b1, SADC_CTRL_ADDR, {24'h0, ch, 2'h3});
      n = 0;
      sh = 1'b0;
      while (convIrq !== 1'b1 && n < 2000) begin
         @(negedge clk);
         n++;
         if (sh && !sampleHold) chk(32'(dacTrial), 32'h200);
         sh = sampleHold;
      end
      chk(32'(n >= 11 * div_of(cks) && n <= 12 * div_of(cks) + 6), 32'h1);
      apb(1'b0, SADC_CTRL_ADDR, 32'h0);
      chk(32'(rd[SADC_GO_BIT]), 32'h0);
      apb(1'b0, SADC_RESH_ADDR, 32'h0);
      chk(rd, res_of(r, just, 1'b1));
      apb(1'b0, SADC_RESL_ADDR, 32'h0);
      chk(rd, res_of(r, just, 1'b0));
      apb(1'b1, SADC_STAT_ADDR, 32'h1);
      @(negedge clk);
      chk(32'(convIrq), 32'h0);
   endtask : conv
   task automatic finish_test();
      $display("checks %0d mismatches %0d", n_tests, n_fail);
      if (n_fail == 0 && n_tests > 0) $display("Test passed");
      else $display("Test failed");
      $finish;
   endtask : finish_test
   // ********
   // main sequence
   // ********
   initial begin
      resetn = 1'b0;
      psel = 1'b0;
      penable = 1'b0;
      pwrite = 1'b0;
      paddr = 8'h00;
      pwdata = 32'h0;
      vin = 10'h000;
      repeat (12) @(posedge clk);
      resetn <= 1'b1;
      for (int i = 0; i < 5; i++) begin
         apb(1'b0, 8'(4 * i), 32'h0);
         chk(rd, 32'h0);
         chk(32'(err), 32'h0);
      end
      apb(1'b1, 8'h14, 32'hffff);
      chk(32'(err), 32'h1);
      apb(1'b0, 8'h14, 32'h0);
      chk(rd, 32'h0);
      $display("reset and unmapped test done");
      apb(1'b1, SADC_CTRL_ADDR, 32'h2);
      repeat (200) @(posedge clk);
      @(negedge clk);
      chk(32'(convIrq), 32'h0);
      $display("start without enable test done");
      for (int c = 0; c < 8; c++) conv(3'(c), 1'(rnd()));
      $display("clock selection test done");
      @(posedge clk);
      vin <= 10'h2aa;
      apb(1'b1, SADC_CFG_ADDR, 32'h68);
      apb(1'b1, SADC_CTRL_ADDR, 32'h1);
      apb(1'b1, SADC_CTRL_ADDR, 32'h3);
      repeat (285) @(posedge clk);
      apb(1'b1, SADC_CTRL_ADDR, 32'h1);
      @(negedge clk);
      chk(32'(convIrq), 32'h1);
      apb(1'b0, SADC_RESL_ADDR, 32'h0);
      chk(rd, 32'hff);
      apb(1'b0, SADC_RESH_ADDR, 32'h0);
      chk(rd, 32'h2);
      $display("abort test done");
      finish_test();
   end
   // watchdog at about eight times the expected run length
   initial begin
      #200000;
      n_fail++;
      finish_test();
   end
endmodule : tb
